// ==== inc/apo_pkg.sv ====
/*
  Shared constants for the converter output control block: register map,
  field positions, reset values, the rate-select codes and the cycle
  counts of the output pipeline and the warm-up window.
  Assumes a 32-bit Avalon-MM slave with byte addressing and one clock.
*/
package apo_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL       = 5'h00;
  localparam logic [4:0] ADDR_STATUS     = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_MASK   = 5'h0C;
  localparam logic [4:0] ADDR_LAST_CODE  = 5'h10;

  // Control register fields
  localparam int CTRL_FORCE_SLEEP_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  // Status register fields
  localparam int STAT_RATE_LSB      = 0;
  localparam int STAT_RATE_MSB      = 1;
  localparam int STAT_EXT_REF_BIT   = 2;
  localparam int STAT_SLEEP_BIT     = 3;
  localparam int STAT_VALID_BIT     = 4;

  // Interrupt status and mask layout
  localparam int IRQ_WIDTH          = 3;
  localparam int IRQ_OVERRANGE_BIT  = 0;
  localparam int IRQ_WARMUP_BIT     = 1;
  localparam int IRQ_RATE_CHG_BIT   = 2;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

  // Last-code register fields
  localparam int LAST_OR_BIT        = 12;

  // Rate-select codes, upper bit first
  typedef enum logic [1:0] {
    RATE_SLEEP  = 2'h0,
    RATE_UP_5   = 2'h1,
    RATE_UP_20  = 2'h2,
    RATE_UP_28  = 2'h3
  } apo_rate_type;

  // Level the pull devices give an undriven rate-select pin
  localparam logic PULL_RATE_HI = 1'h1;
  localparam logic PULL_RATE_LO = 1'h0;

  // Result format
  localparam int CODE_WIDTH   = 12;
  localparam int LEVEL_WIDTH  = 14;
  localparam logic signed [LEVEL_WIDTH-1:0] LEVEL_MIN = 14'sh3800;
  localparam logic signed [LEVEL_WIDTH-1:0] LEVEL_MAX = 14'sh07FF;
  localparam logic [CODE_WIDTH-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_WIDTH-1:0] CODE_FULL = 12'hFFF;

  // Converter clock counts
  localparam int PIPE_DEPTH     = 8;
  localparam int WARMUP_CYCLES  = 20;
  localparam logic [4:0] WARMUP_LAST = 5'(WARMUP_CYCLES);

endpackage : apo_pkg

// ==== verilog/apo_output_ctrl.sv ====
/*
  Digital control and output side of a 12-bit pipelined sampling
  converter: reference select, two-pin rate/sleep programming with pull
  defaults, falling-edge sampling, eight-clock result pipeline, range
  flag, warm-up tracking, and an Avalon-MM register slave with interrupt.
  Assumes mclk is much faster than the converter clock, which arrives
  on a pin and is sampled like every other pin input.
*/
// Our own choices: the Avalon-MM register port and the placing of the registers.

module apo_output_ctrl
  import apo_pkg::*;
(
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Converter pins
  input  wire logic                       conv_clk,
  input  wire logic                       ref_source_select,
  input  wire logic                       rate_select_hi,
  input  wire logic                       rate_select_hi_driven,
  input  wire logic                       rate_select_lo,
  input  wire logic                       rate_select_lo_driven,
  input  wire logic signed [LEVEL_WIDTH-1:0] analog_level,
  // Result outputs
  output logic        [CODE_WIDTH-1:0]    sample_code_bus,
  output logic                            out_of_range,
  output logic                            data_valid,
  // Reference and power state
  output logic                            ref_external_active,
  output logic                            ref_internal_power,
  output logic        [1:0]               rate_setting,
  output logic                            sleep_active,
  // Avalon-MM slave
  input  wire logic   [4:0]               avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic   [31:0]              avs_writedata,
  input  wire logic   [3:0]               avs_byteenable,
  output logic        [31:0]              avs_readdata,
  output logic                            avs_waitrequest,
  // Interrupt
  output logic                            irq
);

  // Synchroniser stages for all pin inputs
  localparam int PIN_WIDTH = 6 + LEVEL_WIDTH;

  logic [PIN_WIDTH-1:0]         pin_meta;         // First stage, read only by second
  logic [PIN_WIDTH-1:0]         pin_sync;         // Second stage, safe to use
  logic                         conv_clk_prev;    // Delayed copy for edge detect
  logic                         conv_fall;        // Falling edge of converter clock
  logic                         sync_clk;         // Synchronised converter clock
  logic                         sync_ref;         // Synchronised reference select
  logic                         sync_hi;          // Synchronised upper rate pin
  logic                         sync_hi_drv;      // Upper pin driven from outside
  logic                         sync_lo;          // Synchronised lower rate pin
  logic                         sync_lo_drv;      // Lower pin driven from outside
  logic signed [LEVEL_WIDTH-1:0] sync_level;      // Synchronised input level

  logic [1:0]                   pin_rate;         // Rate code after pulls
  logic                         sleep_now;        // Sleep from pins or software
  logic [CODE_WIDTH-1:0]        next_code;        // Converted code for this sample
  logic                         next_or;          // Range flag for this sample

  logic [CODE_WIDTH-1:0]        code_pipe [PIPE_DEPTH];  // Results in flight
  logic                         or_pipe   [PIPE_DEPTH];  // Range flags in flight
  logic [4:0]                   warm_count;       // Converter clocks since reset

  logic [31:0]                  ctrl;             // Control register
  logic [IRQ_WIDTH-1:0]         irq_status;       // Sticky event bits
  logic [IRQ_WIDTH-1:0]         irq_mask;         // Event enables
  logic [IRQ_WIDTH-1:0]         irq_event;        // Events this cycle
  logic [1:0]                   rate_prev;        // Rate seen last cycle
  logic                         bus_req;          // Read or write pending
  logic                         bus_take;         // Request completes this edge
  logic [31:0]                  read_mux;         // Read data for current address

  // Two-flop synchroniser on every pin input
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {conv_clk, ref_source_select, rate_select_hi,
                   rate_select_hi_driven, rate_select_lo,
                   rate_select_lo_driven, analog_level};
      pin_sync <= pin_meta;
    end
  end

  // Unpack the synchronised pins
  assign {sync_clk, sync_ref, sync_hi, sync_hi_drv, sync_lo, sync_lo_drv,
          sync_level} = pin_sync;

  // Edge detector reads only the second stage
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conv_clk_prev <= 1'b0;
    end else begin
      conv_clk_prev <= sync_clk;
    end
  end

  assign conv_fall = conv_clk_prev & ~sync_clk;

  // pull devices fill in undriven pins
  always_comb begin
    pin_rate[1] = sync_hi_drv ? sync_hi : PULL_RATE_HI;
    pin_rate[0] = sync_lo_drv ? sync_lo : PULL_RATE_LO;
  end

  assign sleep_now = (pin_rate == RATE_SLEEP) || ctrl[CTRL_FORCE_SLEEP_BIT];

  // clamp and flag inputs beyond full scale
  always_comb begin
    next_or   = 1'b0;
    next_code = CODE_ZERO;
    if (sync_level < LEVEL_MIN) begin
      next_or   = 1'b1;
      next_code = CODE_ZERO;
    end else if (sync_level > LEVEL_MAX) begin
      next_or   = 1'b1;
      next_code = CODE_FULL;
    end else begin
      // offset binary is two's complement with MSB inverted
      next_code = {~sync_level[CODE_WIDTH-1], sync_level[CODE_WIDTH-2:0]};
    end
  end

  // first stage takes the sample on the falling edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      code_pipe[0] <= CODE_ZERO;
      or_pipe[0]   <= 1'b0;
    end else if (conv_fall && !sleep_now) begin
      code_pipe[0] <= next_code;
      or_pipe[0]   <= next_or;
    end
  end

  // remaining stages shift once per converter clock
  for (genvar i = 1; i < PIPE_DEPTH; i++) begin : g_stage
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        code_pipe[i] <= CODE_ZERO;
        or_pipe[i]   <= 1'b0;
      end else if (conv_fall && !sleep_now) begin
        code_pipe[i] <= code_pipe[i-1];
        or_pipe[i]   <= or_pipe[i-1];
      end
    end
  end

  // eighth falling edge after sampling drives the pins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sample_code_bus <= CODE_ZERO;
      out_of_range    <= 1'b0;
    end else if (conv_fall && !sleep_now) begin
      // Changes on the falling edge, so it is stable at the rising edge
      sample_code_bus <= code_pipe[PIPE_DEPTH-1];
      out_of_range    <= or_pipe[PIPE_DEPTH-1];
    end
  end

  // count converter clocks until the output is trustworthy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      warm_count <= 5'h00;
      data_valid <= 1'b0;
    end else if (conv_fall && warm_count != WARMUP_LAST) begin
      // Sleep does not restart the count; the capture side waits itself
      warm_count <= warm_count + 5'h01;
      data_valid <= (warm_count + 5'h01) == WARMUP_LAST;
    end
  end

  // reference source follows the select pin
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ref_external_active <= 1'b0;
      ref_internal_power  <= 1'b1;
    end else begin
      ref_external_active <= sync_ref;
      // internal reference off while external one is used
      ref_internal_power  <= ~sync_ref;
    end
  end

  // publish decoded rate and sleep state
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rate_setting <= RATE_UP_20;
      sleep_active <= 1'b0;
      rate_prev    <= RATE_UP_20;
    end else begin
      rate_setting <= pin_rate;
      sleep_active <= sleep_now;
      rate_prev    <= pin_rate;
    end
  end

  // Events that raise sticky interrupt bits
  always_comb begin
    irq_event                    = '0;
    irq_event[IRQ_OVERRANGE_BIT] = conv_fall && !sleep_now && or_pipe[PIPE_DEPTH-1];
    irq_event[IRQ_WARMUP_BIT]    = conv_fall && (warm_count + 5'h01) == WARMUP_LAST;
    irq_event[IRQ_RATE_CHG_BIT]  = pin_rate != rate_prev;
  end

  // Bus handshake terms
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;

  // One wait cycle, then a one-cycle low waitrequest per request
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req) begin
      avs_waitrequest <= 1'b0;
    end
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (avs_address)
      ADDR_CTRL:       read_mux = ctrl;
      ADDR_STATUS: begin
        read_mux[STAT_RATE_MSB:STAT_RATE_LSB] = rate_setting;
        read_mux[STAT_EXT_REF_BIT]            = ref_external_active;
        read_mux[STAT_SLEEP_BIT]              = sleep_active;
        read_mux[STAT_VALID_BIT]              = data_valid;
      end
      ADDR_IRQ_STATUS: read_mux[IRQ_WIDTH-1:0] = irq_status;
      ADDR_IRQ_MASK:   read_mux[IRQ_WIDTH-1:0] = irq_mask;
      ADDR_LAST_CODE: begin
        read_mux[CODE_WIDTH-1:0] = sample_code_bus;
        read_mux[LAST_OR_BIT]    = out_of_range;
      end
      default:         read_mux = 32'h0000_0000;
    endcase
  end

  // Read data is prepared while waitrequest is still high
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= read_mux;
    end
  end

  // Control register, low byte only carries fields
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (bus_take && avs_write && avs_address == ADDR_CTRL
                 && avs_byteenable[0]) begin
      ctrl[CTRL_FORCE_SLEEP_BIT] <= avs_writedata[CTRL_FORCE_SLEEP_BIT];
    end
  end

  // Interrupt mask register
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_mask <= IRQ_RESET;
    end else if (bus_take && avs_write && avs_address == ADDR_IRQ_MASK
                 && avs_byteenable[0]) begin
      irq_mask <= avs_writedata[IRQ_WIDTH-1:0];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_status <= IRQ_RESET;
    end else if (bus_take && avs_write && avs_address == ADDR_IRQ_STATUS
                 && avs_byteenable[0]) begin
      irq_status <= (irq_status & ~avs_writedata[IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // Level interrupt from any unmasked status bit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : apo_output_ctrl

// ==== verif/apo_output_ctrl_props.sv ====
/* Port checker for the converter output block.
   Assumes one clock, mclk, and a synchronous active-low reset. */
module apo_output_ctrl_props
  import apo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Pins
  input wire logic conv_clk,
  input wire logic ref_source_select,
  input wire logic rate_select_hi,
  input wire logic rate_select_hi_driven,
  input wire logic rate_select_lo,
  input wire logic rate_select_lo_driven,
  // Results and state
  input wire logic [CODE_WIDTH-1:0] sample_code_bus,
  input wire logic out_of_range,
  input wire logic data_valid,
  input wire logic ref_external_active,
  input wire logic ref_internal_power,
  input wire logic [1:0] rate_setting,
  input wire logic sleep_active,
  // Bus and interrupt
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pin_code; // Pin code after the pulls
  // Floating pins take the pull level
  assign pin_code = {rate_select_hi_driven ? rate_select_hi : PULL_RATE_HI,
                     rate_select_lo_driven ? rate_select_lo : PULL_RATE_LO};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Window of 5 covers the two-flop synchroniser
  chk_ref_follows: assert property ($stable(ref_source_select) [*5] |->
    ref_external_active == ref_source_select) else $error("ref select not followed");
  chk_ref_power: assert property ($stable(ref_source_select) [*5] |->
    ref_internal_power == !ref_source_select) else $error("internal ref powered with external ref");
  chk_rate_decode: assert property ($stable(pin_code) [*5] |-> rate_setting == pin_code)
    else $error("rate code wrong");
  chk_rate_pull: assert property ((!rate_select_hi_driven && !rate_select_lo_driven) [*5]
    |-> rate_setting == RATE_UP_20) else $error("pull default wrong");
  chk_sleep_code: assert property ((pin_code == RATE_SLEEP) [*5] |-> sleep_active)
    else $error("sleep code ignored");
  chk_sleep_hold: assert property (sleep_active [*2] |-> $stable(sample_code_bus))
    else $error("code moved in sleep");
  // Code may move only after a falling edge
  chk_code_hold: assert property (conv_clk [*6] |->
    $stable(sample_code_bus) && $stable(out_of_range)) else $error("code moved while high");
  chk_range_clamp: assert property (out_of_range |->
    sample_code_bus == CODE_ZERO || sample_code_bus == CODE_FULL) else $error("bad clamp");
  chk_valid_sticky: assert property (data_valid |=> data_valid)
    else $error("data valid dropped");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait not one cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  cover property ($rose(out_of_range));
  cover property ($rose(data_valid));
  cover property (sleep_active && !conv_clk);
  cover property ($rose(irq));
endmodule : apo_output_ctrl_props

bind apo_output_ctrl apo_output_ctrl_props u_props (.*);

// ==== verif/apo_capture_model.sv ====
/* Capture logic at the far side: latches each result on the rising
   converter clock and flags words that may be trusted.
   Assumes the bench makes conv_clk. */
module apo_capture_model
  import apo_pkg::*;
(
  // Converter side
  input wire logic conv_clk,
  input wire logic [CODE_WIDTH-1:0] sample_code_bus,
  input wire logic out_of_range,
  input wire logic sleep_active,
  // Captured word
  output logic [CODE_WIDTH-1:0] cap_code,
  output logic cap_range,
  output logic cap_keep
);
  timeunit 1ns;
  timeprecision 100ps;
  int settle = 0; // Edges since power-up or wake
  always @(posedge conv_clk) begin
    cap_code <= sample_code_bus;
    cap_range <= out_of_range;
    // Restart conservatively after sleep
    settle <= sleep_active ? 0 : settle + 1;
  end
  assign cap_keep = settle > WARMUP_CYCLES;
endmodule : apo_capture_model

// ==== verif/test_adc_pipeline_output_ctrl.sv ====
/* Self-checking bench for the converter output block and its capture
   partner. Assumes the checker is bound to the block. */
module test_adc_pipeline_output_ctrl
  import apo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, conv_clk, ref_source_select, rate_select_hi, rate_select_lo;
  logic rate_select_hi_driven, rate_select_lo_driven, out_of_range, data_valid;
  logic ref_external_active, ref_internal_power, sleep_active, irq, cap_range, cap_keep;
  logic signed [LEVEL_WIDTH-1:0] analog_level;
  logic [CODE_WIDTH-1:0] sample_code_bus, cap_code;
  logic [1:0] rate_setting;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  int miscompares = 0;
  int comparisons = 0;
  // Levels with both clamps and both full-scale ends
  logic signed [13:0] lvl_tbl [8] = '{-2048, 2047, 0, -3000, 3000, 1, -1, 2046};
  apo_output_ctrl DUT (
    .mclk                  (mclk),
    .reset_n               (reset_n),
    .conv_clk              (conv_clk),
    .ref_source_select     (ref_source_select),
    .rate_select_hi        (rate_select_hi),
    .rate_select_hi_driven (rate_select_hi_driven),
    .rate_select_lo        (rate_select_lo),
    .rate_select_lo_driven (rate_select_lo_driven),
    .analog_level          (analog_level),
    .sample_code_bus       (sample_code_bus),
    .out_of_range          (out_of_range),
    .data_valid            (data_valid),
    .ref_external_active   (ref_external_active),
    .ref_internal_power    (ref_internal_power),
    .rate_setting          (rate_setting),
    .sleep_active          (sleep_active),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .irq                   (irq)
  );
  apo_capture_model u_cap (.conv_clk(conv_clk), .sample_code_bus(sample_code_bus),
    .out_of_range(out_of_range), .sleep_active(sleep_active), .cap_code(cap_code),
    .cap_range(cap_range), .cap_keep(cap_keep));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: %s", $time, what);
    end
  endtask : chk
  // One bus word; an idle edge after, so requests never merge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
    // Slave answers after exactly one wait cycle; a hang is left to the watchdog
    chk(32'(n), 2, "wait cycles");
  endtask : xfer
  // Expected {flag, code} for a level
  function automatic logic [12:0] enc(input logic signed [13:0] l);
    if (l < LEVEL_MIN) return {1'b1, CODE_ZERO};
    if (l > LEVEL_MAX) return {1'b1, CODE_FULL};
    return {1'b0, 12'(l - LEVEL_MIN)};
  endfunction : enc
  function automatic logic signed [13:0] lvl_of(input int j);
    return (j < 32) ? lvl_tbl[j % 8] : 14'(j * 3);
  endfunction : lvl_of
  // One converter period of 11 mclk: 5 high, 5 low, then 1 high
  task automatic conv_cycle(input logic signed [13:0] l);
    analog_level <= l;
    repeat (5) @(posedge mclk);
    conv_clk <= 0;
    repeat (5) @(posedge mclk);
    conv_clk <= 1;
    @(posedge mclk);
  endtask : conv_cycle
  task automatic t_regs();
    xfer(0, ADDR_STATUS, 0); chk(q, 32'h2, "status reset");
    xfer(0, ADDR_IRQ_STATUS, 0); chk(q, 0, "irq status reset");
    xfer(0, ADDR_IRQ_MASK, 0); chk(q, 0, "mask reset");
    xfer(1, 5'h14, 32'hF); xfer(0, 5'h14, 0); chk(q, 0, "unmapped");
    xfer(1, ADDR_CTRL, 1); xfer(0, ADDR_CTRL, 0); chk(q, 1, "ctrl rw");
    chk(32'(sleep_active), 1, "forced sleep");
    xfer(1, ADDR_CTRL, 0);
  endtask : t_regs
  task automatic t_ref();
    for (int r = 1; r >= 0; r--) begin
      ref_source_select <= 1'(r);
      repeat (6) @(posedge mclk);
      chk(32'({ref_external_active, ref_internal_power}), 32'(r ? 2 : 1), "ref");
    end
  endtask : t_ref
  task automatic t_pipe();
    for (int j = 1; j <= 44; j++) begin
      conv_cycle(lvl_of(j));
      if (j == 19 || j == 20) chk(32'(data_valid), 32'(j == 20), "warm-up");
      if (cap_keep) chk(32'({cap_range, cap_code}), 32'(enc(lvl_of(j - 8))), "word");
    end
    xfer(0, ADDR_LAST_CODE, 0); chk(q, 32'(enc(lvl_of(36))), "last code");
  endtask : t_pipe
  task automatic t_irq();
    xfer(0, ADDR_IRQ_STATUS, 0); chk(q & 3, 3, "events");
    chk(32'(irq), 0, "masked irq");
    xfer(1, ADDR_IRQ_MASK, 1);
    // Interrupt output is registered one edge after the mask lands
    @(posedge mclk);
    chk(32'(irq), 1, "irq raised");
    xfer(1, ADDR_IRQ_STATUS, 3); xfer(0, ADDR_IRQ_STATUS, 0); chk(q & 3, 0, "w1c");
    chk(32'(irq), 0, "irq cleared");
  endtask : t_irq
  task automatic t_rate();
    logic [CODE_WIDTH-1:0] hold;
    for (int c = 0; c < 4; c++) begin
      {rate_select_hi, rate_select_lo} <= 2'(c);
      {rate_select_hi_driven, rate_select_lo_driven} <= 2'b11;
      repeat (6) @(posedge mclk);
      xfer(0, ADDR_STATUS, 0); chk(q & 32'hB, 32'(c) | (c ? 0 : 8), "rate");
      if (c == 0) begin
        hold = sample_code_bus;
        repeat (3) conv_cycle(14'sh0123);
        chk(32'(sample_code_bus), 32'(hold), "sleep freeze");
        chk(32'(cap_keep), 0, "discard after sleep");
      end
    end
    {rate_select_hi, rate_select_lo, rate_select_hi_driven, rate_select_lo_driven} <= 4'h4;
    repeat (6) @(posedge mclk);
    chk(32'(rate_setting), 32'(RATE_UP_20), "pull default");
    xfer(0, ADDR_IRQ_STATUS, 0); chk(q & 4, 4, "rate event");
  endtask : t_rate
  task automatic results();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Watchdog, well past the expected run
  initial begin
    repeat (8000) @(posedge mclk);
    miscompares++;
    $display("[FAIL] %0t: timeout", $time);
    results();
  end
  initial begin
    {reset_n, ref_source_select, rate_select_hi, rate_select_hi_driven} = 0;
    {rate_select_lo, rate_select_lo_driven, avs_read, avs_write} = 0;
    {avs_address, avs_writedata, analog_level} = 0;
    conv_clk = 1;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    t_regs();
    t_ref();
    t_pipe();
    t_irq();
    t_rate();
    results();
  end
endmodule : test_adc_pipeline_output_ctrl
